/* common/qfp_pkg.sv */
// Function
// R01: enable low turns channel switch off
// R02: enable high or floating means enabled
// R03: protection shutdown overrides asserted enable
// R04: breaker at twice overload trips instantly
// R05: overload starts trip timer, expiry shuts off
// R06: current drop before expiry clears timer
// R07: overtemperature shuts channel off in any state
// R08: auto-retry restarts after thermal hysteresis cooling
// R09: latched version stays off until reset
// R10: trip affects only the tripping channel
// R11: fault low on thermal, breaker or timer trip
// R12: fault released when clear, normal or lockout
// R13: one shared fault line, channel not identified
// R14: turn-on uses linear ramp, default duration
// R15: system grounds unused channel supply and enable
// R16: controller should drive enables high actively
// R17: auto-retry restarts breaker trip after interval
// R18: latched channel resumes only on enable toggle
// R19: per-channel counters, cleared when channel disabled; a tripped channel in latched mode keeps its retry timer counting
package qfp_pkg;
	localparam int NUM_CH     = 4;
	localparam int CLK_HZ     = 40_000_000;
	// trip interval minimum, in microseconds
	localparam int TRIP_US    = 1500;
	localparam int TRIP_CYC   = (TRIP_US * (CLK_HZ / 1_000_000));
	// ramp time, in microseconds
	localparam int RAMP_US    = 1500;
	localparam int RAMP_CYC   = (RAMP_US * (CLK_HZ / 1_000_000));
	// auto-retry interval, in microseconds (no printed figure)
	localparam int RETRY_US   = 100_000;
	localparam int RETRY_CYC  = (RETRY_US * (CLK_HZ / 1_000_000));
	localparam int CNT_W      = 23;
	localparam int RAMP_W     = 16;
	localparam logic [RAMP_W-1:0] RAMP_FULL = 16'hffff;

	// avalon register offsets (byte addresses)
	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_IRQ    = 4'h8;
	localparam logic [3:0] OFF_MASK   = 4'hc;
	// ctrl bit 0: 1 = auto-retry version, 0 = latched version
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		QFP_OFF,
		QFP_RAMP,
		QFP_ON,
		QFP_TRIP
	} qfp_state_type;

	typedef enum logic [1:0] {
		QFP_CAUSE_NONE,
		QFP_CAUSE_THERM,
		QFP_CAUSE_BRK,
		QFP_CAUSE_TMR
	} qfp_cause_type;

	// saturating increment shared by the channel counters
	function automatic logic [CNT_W-1:0] qfp_inc(input logic [CNT_W-1:0] v);
		qfp_inc = (v == {CNT_W{1'b1}}) ? v : v + 23'h00_0001;
	endfunction : qfp_inc
endpackage : qfp_pkg

/* common/qfp_ch_if.sv */
`timescale 1ns/100ps
// per-channel status carried from a channel to the top
interface qfp_ch_if;
	logic                        switch_on;
	logic                        fault;
	logic [qfp_pkg::RAMP_W-1:0]  ramp;
	qfp_pkg::qfp_cause_type      cause;
	modport chan (output switch_on, output fault, output ramp, output cause);
	modport top  (input switch_on, input fault, input ramp, input cause);
endinterface : qfp_ch_if

/* design/qfp_channel.sv */
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
// one protected channel; channels share nothing but the mode bit and the supply lockout
module qfp_channel (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// controls
	input  wire logic        auto_retry,
	input  wire logic        enable,
	input  wire logic        over_load,
	input  wire logic        over_brk,
	input  wire logic        over_temp,
	input  wire logic        temp_cooled,
	// status
	qfp_ch_if.chan           st
);
	qfp_pkg::qfp_state_type      state;
	qfp_pkg::qfp_state_type      next_state;
	qfp_pkg::qfp_cause_type      cause;
	qfp_pkg::qfp_cause_type      next_cause;
	logic [qfp_pkg::CNT_W-1:0]   trip_cnt;
	logic [qfp_pkg::CNT_W-1:0]   next_trip_cnt;
	logic [qfp_pkg::CNT_W-1:0]   tmr;
	logic [qfp_pkg::CNT_W-1:0]   next_tmr;
	logic [qfp_pkg::RAMP_W-1:0]  ramp;
	logic [qfp_pkg::RAMP_W-1:0]  next_ramp;
	logic                        en_q;
	logic                        en_rise;

	assign en_rise = enable && !en_q;

	// state machine, trip timer and ramp / retry timer
	always_comb begin
		next_state    = state;
		next_cause    = cause;
		next_trip_cnt = '0;
		next_tmr      = '0;
		next_ramp     = ramp;
		unique case (state)
			qfp_pkg::QFP_OFF: begin
				next_ramp = '0;
				if (enable) begin // R02
					next_state = qfp_pkg::QFP_RAMP;
				end
			end
			qfp_pkg::QFP_RAMP, qfp_pkg::QFP_ON: begin
				// trip timer runs only while above overload level
				if (over_load) begin // R05
					next_trip_cnt = qfp_pkg::qfp_inc(trip_cnt);
				end // otherwise cleared: R06
				if (state == qfp_pkg::QFP_RAMP) begin
					next_tmr  = qfp_pkg::qfp_inc(tmr); // R14
					next_ramp = 16'(({9'h000, tmr} * 32'(qfp_pkg::RAMP_FULL))
						/ qfp_pkg::RAMP_CYC);
					if (tmr >= 23'(qfp_pkg::RAMP_CYC - 1)) begin
						next_state = qfp_pkg::QFP_ON;
						next_ramp  = qfp_pkg::RAMP_FULL;
					end
				end
				// thermal first, checked in any on state
				if (over_temp) begin // R07
					next_state = qfp_pkg::QFP_TRIP; // R03
					next_cause = qfp_pkg::QFP_CAUSE_THERM;
				end else if (over_brk) begin // R04
					next_state = qfp_pkg::QFP_TRIP;
					next_cause = qfp_pkg::QFP_CAUSE_BRK;
				end else if (over_load
						&& trip_cnt >= 23'(qfp_pkg::TRIP_CYC - 1)) begin // R05
					next_state = qfp_pkg::QFP_TRIP;
					next_cause = qfp_pkg::QFP_CAUSE_TMR;
				end
				if (!enable) begin // R01
					next_state = qfp_pkg::QFP_OFF;
					next_cause = qfp_pkg::QFP_CAUSE_NONE;
				end
				// the end of the ramp must not restart a running trip interval
				if (next_state != state) begin
					next_tmr = '0;
				end
				if (next_state == qfp_pkg::QFP_OFF || next_state == qfp_pkg::QFP_TRIP) begin
					next_trip_cnt = '0; // R19
				end
			end
			qfp_pkg::QFP_TRIP: begin
				next_ramp = '0;
				next_tmr  = qfp_pkg::qfp_inc(tmr); // R19
				// a disabled channel never restarts by itself
				if (auto_retry && enable) begin // R01
					// thermal waits for hysteresis, others for retry interval
					if ((cause == qfp_pkg::QFP_CAUSE_THERM && temp_cooled) // R08
						|| (cause != qfp_pkg::QFP_CAUSE_THERM
						&& tmr >= 23'(qfp_pkg::RETRY_CYC - 1))) begin // R17
						next_state = qfp_pkg::QFP_RAMP;
						next_cause = qfp_pkg::QFP_CAUSE_NONE;
						next_tmr   = '0;
					end
				end else if (en_rise) begin // R09 R18
					// a cold channel only; a hot one stays tripped
					if (!over_temp) begin
						next_state = qfp_pkg::QFP_RAMP;
						next_cause = qfp_pkg::QFP_CAUSE_NONE;
						next_tmr   = '0;
					end
				end
				if (!enable && auto_retry) begin // R19
					next_tmr = '0;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state    <= qfp_pkg::QFP_OFF;
			cause    <= qfp_pkg::QFP_CAUSE_NONE;
			trip_cnt <= '0;
			tmr      <= '0;
			ramp     <= '0;
			en_q     <= 1'b1; // idle level of the pulled-up enable, no false edge
		end else begin
			state    <= next_state;
			cause    <= next_cause;
			trip_cnt <= next_trip_cnt;
			tmr      <= next_tmr;
			ramp     <= next_ramp;
			en_q     <= enable;
		end
	end

	assign st.switch_on = (state == qfp_pkg::QFP_RAMP) || (state == qfp_pkg::QFP_ON); // R03
	assign st.fault     = (state == qfp_pkg::QFP_TRIP); // R11
	assign st.ramp      = ramp;
	assign st.cause     = cause;
endmodule : qfp_channel

/* design/qfp_avalon_regs.sv */
`timescale 1ns/100ps
// avalon-mm slave: ctrl, live status, sticky irq status, mask
module qfp_avalon_regs (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// avalon slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// block side
	input  wire logic [31:0] live_status,
	input  wire logic [3:0]  events,
	output logic             auto_retry,
	output logic             irq
);
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [3:0]  irq_st;
	logic [3:0]  next_irq_st;
	logic [3:0]  mask;
	logic [3:0]  next_mask;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic        ack;
	logic        next_ack;

	// one wait state: request answered at the second edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	always_comb begin
		next_ctrl   = ctrl;
		next_mask   = mask;
		next_rdata  = rdata;
		next_ack    = (avs_read || avs_write) && !ack;
		next_irq_st = irq_st;
		// a write lands only at the edge that accepts it
		if (avs_write && ack) begin
			unique case (avs_address)
				qfp_pkg::OFF_CTRL: next_ctrl = {31'h0000_0000, avs_writedata[0]};
				qfp_pkg::OFF_MASK: next_mask = avs_writedata[3:0];
				default: ;
			endcase
		end
		if (avs_read && !ack) begin
			unique case (avs_address)
				qfp_pkg::OFF_CTRL:   next_rdata = ctrl;
				qfp_pkg::OFF_STATUS: next_rdata = live_status;
				qfp_pkg::OFF_IRQ:    next_rdata = {28'h000_0000, irq_st};
				qfp_pkg::OFF_MASK:   next_rdata = {28'h000_0000, mask};
				default:             next_rdata = 32'h0000_0000;
			endcase
		end
		// clear at the accepting edge only the bits that were reported
		if (avs_read && ack && avs_address == qfp_pkg::OFF_IRQ) begin
			next_irq_st = irq_st & ~rdata[3:0];
		end
		next_irq_st = next_irq_st | events; // a set beats the read clear
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl   <= qfp_pkg::CTRL_RESET;
			mask   <= qfp_pkg::MASK_RESET[3:0];
			irq_st <= 4'h0;
			rdata  <= 32'h0000_0000;
			ack    <= 1'b0;
		end else begin
			ctrl   <= next_ctrl;
			mask   <= next_mask;
			irq_st <= next_irq_st;
			rdata  <= next_rdata;
			ack    <= next_ack;
		end
	end

	assign avs_readdata = rdata;
	assign auto_retry   = ctrl[0];
	assign irq          = |(irq_st & mask);
endmodule : qfp_avalon_regs

/* design/qfp_fuse_ctrl.sv */
`timescale 1ns/100ps
// four-channel electronic fuse control
module qfp_fuse_ctrl (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// enables, already resolved to 1 when floating
	input  wire logic [3:0]  channel_enable_in,
	// comparator and sensor levels per channel
	input  wire logic [3:0]  overload_threshold,
	input  wire logic [3:0]  breaker_threshold,
	input  wire logic [3:0]  over_temp,
	input  wire logic [3:0]  temp_cooled,
	input  wire logic        supply_low_lockout,
	// switch drive
	output logic [3:0]       channel_load_out,
	output logic [63:0]      turn_on_ramp_time,
	// shared open-drain fault
	output logic             fault_n_out,
	output logic             fault_n_oe,
	// avalon slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq
);
	logic        auto_retry;
	logic [3:0]  on_vec;
	logic [3:0]  flt_vec;
	logic [3:0]  flt_q;
	logic [3:0]  next_flt_q;
	logic        fault_q;
	logic        next_fault_q;
	logic [31:0] live_status;

	// each channel owns its own state and counters
	for (genvar c = 0; c < 4; c++) begin : g_ch
		qfp_ch_if chi ();
		qfp_channel u_ch (
			.mclk        (mclk),
			.reset       (reset),
			.auto_retry  (auto_retry),
			.enable      (channel_enable_in[c] && !supply_low_lockout), // R01 R02 R10
			.over_load   (overload_threshold[c]),
			.over_brk    (breaker_threshold[c]),
			.over_temp   (over_temp[c]),
			.temp_cooled (temp_cooled[c]),
			.st          (chi.chan)
		);
		assign on_vec[c]  = chi.switch_on;
		assign flt_vec[c] = chi.fault;
		assign turn_on_ramp_time[c*16 +: 16] = chi.ramp; // R14
	end

	// fault line: any channel, no identity; off in lockout
	always_comb begin
		next_flt_q   = flt_vec;
		next_fault_q = (|flt_vec) && !supply_low_lockout; // R11 R12 R13
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			flt_q   <= 4'h0;
			fault_q <= 1'b0;
		end else begin
			flt_q   <= next_flt_q;
			fault_q <= next_fault_q;
		end
	end

	assign channel_load_out = on_vec;
	assign fault_n_out      = 1'b0;
	assign fault_n_oe       = fault_q; // R12
	assign live_status      = {20'h0_0000, flt_vec, on_vec, 4'h0} | {28'h000_0000, flt_vec};

	qfp_avalon_regs u_regs (
		.mclk            (mclk),
		.reset           (reset),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.live_status     (live_status),
		.events          (flt_vec & ~flt_q),
		.auto_retry      (auto_retry),
		.irq             (irq)
	);
endmodule : qfp_fuse_ctrl

/* sim/qfp_fuse_asserts.sv */
`timescale 1ns/100ps
// ********************
// protection checker
// ********************
module qfp_fuse_asserts (
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset,
	// channel inputs
	input wire logic [3:0]  channel_enable_in,
	input wire logic [3:0]  overload_threshold,
	input wire logic [3:0]  breaker_threshold,
	input wire logic [3:0]  over_temp,
	input wire logic        supply_low_lockout,
	// channel outputs
	input wire logic [3:0]  channel_load_out,
	input wire logic [63:0] turn_on_ramp_time,
	input wire logic        fault_n_oe
);
	logic [15:0] ov_cnt;
	logic [15:0] next_ov_cnt;

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	// overload age of channel 3; saturates so a long hold cannot wrap
	always_comb begin
		next_ov_cnt = 16'h0000;
		if (overload_threshold[3] && channel_enable_in[3])
			next_ov_cnt = (ov_cnt == 16'hffff) ? ov_cnt : ov_cnt + 16'h0001;
	end
	// register the age
	always_ff @(posedge mclk) ov_cnt <= reset ? 16'h0000 : next_ov_cnt;

	AST_EN_OFF: assert property (
		1'b1 |=> (channel_load_out & ~$past(channel_enable_in)) == 4'h0)
		else $error("disabled channel still on");
	AST_EN_ON: assert property (
		$rose(channel_enable_in[2]) && !over_temp[2] && !breaker_threshold[2]
		&& !supply_low_lockout |=> channel_load_out[2])
		else $error("enable rise did not switch on");
	AST_BRK_OFF: assert property (
		1'b1 |=> (channel_load_out & $past(breaker_threshold)) == 4'h0)
		else $error("breaker level did not switch off");
	AST_HOT_OFF: assert property (
		1'b1 |=> (channel_load_out & $past(over_temp)) == 4'h0)
		else $error("hot channel still on");
	AST_FAULT_ON: assert property (
		(|((breaker_threshold | over_temp) & channel_load_out)) && !supply_low_lockout
		|-> ##2 fault_n_oe)
		else $error("fault not pulled low");
	AST_LOCK_REL: assert property (
		supply_low_lockout [*3] |-> !fault_n_oe && channel_load_out == 4'h0)
		else $error("lockout left fault or switch active");
	AST_TMR_TRIP: assert property (
		int'(ov_cnt) > qfp_pkg::TRIP_CYC + 2 |-> !channel_load_out[3])
		else $error("trip interval ran out, channel on");
	AST_TMR_HOLD: assert property (
		channel_load_out[3] && int'(ov_cnt) < qfp_pkg::TRIP_CYC - 2 && channel_enable_in[3]
		&& !breaker_threshold[3] && !over_temp[3] && !supply_low_lockout
		|=> channel_load_out[3])
		else $error("overload tripped early");
	AST_ISOLATE: assert property (
		channel_load_out[1] && channel_enable_in[1] && !supply_low_lockout
		&& !(overload_threshold[1] | breaker_threshold[1] | over_temp[1])
		|=> channel_load_out[1])
		else $error("healthy channel dropped");
	AST_RAMP: assert property (
		channel_load_out[0] && $past(channel_load_out[0])
		|-> turn_on_ramp_time[15:0] >= $past(turn_on_ramp_time[15:0]))
		else $error("ramp went down");
endmodule : qfp_fuse_asserts

bind qfp_fuse_ctrl qfp_fuse_asserts u_asserts (.mclk, .reset, .channel_enable_in,
	.overload_threshold, .breaker_threshold, .over_temp, .supply_low_lockout,
	.channel_load_out, .turn_on_ramp_time, .fault_n_oe);

/* sim/qfp_sys_ctrl_model.sv */
`timescale 1ns/100ps
// ********************
// system controller model
// ********************
module qfp_sys_ctrl_model (
	// clock
	input wire logic        mclk,
	// fault pin of the fuse
	input wire logic        fault_n_out,
	input wire logic        fault_n_oe,
	// controller view
	output logic [3:0]      enable,
	output logic            fault_line
);
	// external pull-up: a released pin reads high
	assign fault_line = fault_n_oe ? fault_n_out : 1'b1;
	// enables are driven, never left floating, to suit inductive loads
	initial enable = 4'hf;
	// new enable levels go out just after an edge
	task automatic set_en(input logic [3:0] v);
		@(posedge mclk);
		enable <= v;
	endtask : set_en
	// a latched trip is cleared only by low then high
	task automatic restart(input int ch);
		set_en(enable & ~(4'h1 << ch));
		set_en(enable | (4'h1 << ch));
	endtask : restart
endmodule : qfp_sys_ctrl_model

/* sim/tb.sv */
`timescale 1ns/100ps
// ********************
// fuse control testbench
// ********************
module tb;
	logic        mclk;
	logic        reset;
	logic [3:0]  enable;
	logic [3:0]  overload_threshold;
	logic [3:0]  breaker_threshold;
	logic [3:0]  over_temp;
	logic [3:0]  temp_cooled;
	logic        supply_low_lockout;
	logic [3:0]  channel_load_out;
	logic [63:0] turn_on_ramp_time;
	logic        fault_n_out;
	logic        fault_n_oe;
	logic        fault_line;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	logic [31:0] rd;
	int          failures;
	int          num_checks;

	qfp_fuse_ctrl dut (.mclk, .reset, .channel_enable_in(enable), .overload_threshold,
		.breaker_threshold, .over_temp, .temp_cooled, .supply_low_lockout,
		.channel_load_out, .turn_on_ramp_time, .fault_n_out, .fault_n_oe, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
	qfp_sys_ctrl_model ctl (.mclk, .fault_n_out, .fault_n_oe, .enable, .fault_line);

	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// request held until waitrequest is seen low at an edge
	// no cycle count assumed; only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= d;
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	// watchdog sized above the long overload hold
	initial begin
		cyc(100000);
		failures++;
		close_out;
	end

	// ********************
	// tests
	// ********************
	initial begin
		reset = 1'b1;
		{overload_threshold, breaker_threshold, over_temp, temp_cooled} = 16'h0000;
		supply_low_lockout = 1'b0;
		{avs_address, avs_read, avs_write, avs_writedata} = 38'h0;
		failures = 0;
		num_checks = 0;
		cyc(8);
		reset <= 1'b0;
		cyc(4);
		chk("load", channel_load_out, 4'hf);
		bus(1'b0, qfp_pkg::OFF_CTRL, 32'h0);
		chk("ctrl", rd, qfp_pkg::CTRL_RESET);
		bus(1'b0, qfp_pkg::OFF_MASK, 32'h0);
		chk("mask", rd, qfp_pkg::MASK_RESET);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", rd, 32'h0000_0000);
		bus(1'b1, qfp_pkg::OFF_MASK, 32'h0000_000f);
		ctl.set_en(4'hb);
		cyc(2);
		chk("load", channel_load_out, 4'hb);
		ctl.set_en(4'hf);
		cyc(2);
		chk("load", channel_load_out, 4'hf);
		// breaker trip on channel 0, latched mode
		breaker_threshold <= 4'h1;
		cyc(1);
		breaker_threshold <= 4'h0;
		cyc(3);
		chk("load", channel_load_out, 4'he);
		chk("fault", fault_line, 1'b0);
		chk("irq", irq, 1'b1);
		bus(1'b0, qfp_pkg::OFF_STATUS, 32'h0);
		chk("status", rd & 32'h0000_00ff, 32'h0000_00e1);
		bus(1'b0, qfp_pkg::OFF_IRQ, 32'h0);
		chk("irq status", rd, 32'h0000_0001);
		bus(1'b0, qfp_pkg::OFF_IRQ, 32'h0);
		chk("irq status", rd, 32'h0000_0000);
		cyc(50);
		chk("load", channel_load_out, 4'he);
		chk("irq", irq, 1'b0);
		ctl.restart(0);
		cyc(3);
		chk("load", channel_load_out, 4'hf);
		chk("fault", fault_line, 1'b1);
		// thermal trip on channel 1, auto-retry mode
		bus(1'b1, qfp_pkg::OFF_CTRL, 32'h0000_0001);
		over_temp <= 4'h2;
		cyc(1);
		over_temp <= 4'h0;
		cyc(20);
		chk("load", channel_load_out, 4'hd);
		chk("fault", fault_line, 1'b0);
		temp_cooled <= 4'h2;
		cyc(1);
		temp_cooled <= 4'h0;
		cyc(3);
		chk("load", channel_load_out, 4'hf);
		chk("fault", fault_line, 1'b1);
		bus(1'b0, qfp_pkg::OFF_IRQ, 32'h0);
		chk("irq status", rd, 32'h0000_0002);
		// overload on channel 3: short, then to the trip, masked
		bus(1'b1, qfp_pkg::OFF_CTRL, 32'h0);
		bus(1'b1, qfp_pkg::OFF_MASK, 32'h0);
		overload_threshold <= 4'h8;
		cyc(1000);
		overload_threshold <= 4'h0;
		cyc(2);
		chk("load", channel_load_out, 4'hf);
		overload_threshold <= 4'h8;
		cyc(qfp_pkg::TRIP_CYC + 4);
		overload_threshold <= 4'h0;
		chk("load", channel_load_out, 4'h7);
		chk("ramp", turn_on_ramp_time[31:0], 32'hffff_ffff);
		chk("ramp", turn_on_ramp_time[63:32], 32'h0000_ffff);
		chk("fault", fault_line, 1'b0);
		chk("irq", irq, 1'b0);
		bus(1'b1, qfp_pkg::OFF_MASK, 32'h0000_0008);
		cyc(2);
		chk("irq", irq, 1'b1);
		bus(1'b0, qfp_pkg::OFF_IRQ, 32'h0);
		chk("irq status", rd, 32'h0000_0008);
		ctl.restart(3);
		cyc(3);
		chk("load", channel_load_out, 4'hf);
		// undervoltage lockout
		supply_low_lockout <= 1'b1;
		cyc(4);
		chk("load", channel_load_out, 4'h0);
		chk("fault", fault_line, 1'b1);
		supply_low_lockout <= 1'b0;
		cyc(2);
		close_out;
	end
endmodule : tb
